// *** inc/rcb_pkg.sv ***
/*
 * rcb_pkg: constants, register map and carrier types of the raster
 * function combiner.
 * Assumes a 32-bit apb register bus and one 40 MHz clock.
 */
package rcb_pkg;

    // ==================================================================
    // data path geometry
    localparam int WORD_W   = 32;
    localparam int PIX_BITS = 8;
    localparam int PIX_N    = WORD_W / PIX_BITS;
    localparam int CODE_W   = 8;
    localparam int CNT_W    = 16;

    // ==================================================================
    // register byte offsets
    localparam logic [7:0] OFS_RFCODE = 8'h00;
    localparam logic [7:0] OFS_BLTCMD = 8'h04;
    localparam logic [7:0] OFS_EXEC   = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_COUNT  = 8'h10;
    localparam logic [7:0] OFS_LAST   = 8'h14;
    localparam logic [7:0] OFS_ACTIVE = 8'h18;

    // ==================================================================
    // field positions
    localparam int CODE_LSB      = 0;
    localparam int CMD_SRC_MONO  = 6;
    localparam int CMD_SRC_CPU   = 7;
    localparam int CMD_PAT_MONO  = 8;
    localparam int EXEC_GO       = 0;
    localparam int EXEC_STOP     = 1;
    localparam int STAT_ACTIVE   = 0;
    localparam int STAT_DROP     = 1;
    localparam int STAT_DONE     = 2;
    localparam int ACT_SRC_MONO  = 8;
    localparam int ACT_SRC_CPU   = 9;
    localparam int ACT_PAT_MONO  = 10;

    // ==================================================================
    // reset values
    localparam logic [CODE_W-1:0] RST_CODE   = 8'h00;
    localparam logic [8:0]        RST_CMD    = 9'h000;
    localparam logic [CNT_W-1:0]  RST_COUNT  = 16'h0000;
    localparam logic [WORD_W-1:0] RST_WORD   = 32'h00000000;

    // ==================================================================
    // carrier types
    typedef struct packed {
        logic [WORD_W-1:0] src_cpu;
        logic [WORD_W-1:0] src_scr;
        logic [WORD_W-1:0] pat;
        logic [WORD_W-1:0] dst;
    } rcb_ops_t;

    typedef struct packed {
        logic              src_mono;
        logic              src_cpu;
        logic              pat_mono;
        logic [CODE_W-1:0] code;
    } rcb_setup_t;

    typedef enum logic [0:0] {
        RCB_IDLE = 1'b0,
        RCB_RUN  = 1'b1
    } rcb_state_t;

endpackage

// *** logic/rcb_expand.sv ***
/*
 * rcb_expand: widens monochrome data to colour pixels, one mono bit
 * per pixel, or passes colour data through.
 * Assumes the caller registers the result where timing needs it.
 */
`timescale 1ns/1ps
`default_nettype none
module rcb_expand #(
    parameter int PIX_BITS = 8,
    parameter int PIX_N    = 4
) (
    // control
    input  wire logic                      mono,
    // data
    input  wire logic [PIX_BITS*PIX_N-1:0] din,
    output logic      [PIX_BITS*PIX_N-1:0] dout
);
    initial begin
        if (PIX_BITS < 1 || PIX_N < 1) begin
            $error("rcb_expand: bad geometry");
        end
    end

    // ==================================================================
    // per-pixel expansion
    genvar gi;
    generate
        for (gi = 0; gi < PIX_N; gi++) begin : g_pix
            // mono bit i fills every bit of pixel i
            assign dout[gi*PIX_BITS +: PIX_BITS] =
                mono ? {PIX_BITS{din[gi]}} : din[gi*PIX_BITS +: PIX_BITS];
        end
    endgenerate
endmodule
`default_nettype wire

// *** logic/rcb_combine.sv ***
/*
 * rcb_combine: three-operand bitwise raster function by truth table.
 * Assumes colour-width operands; the code is stable while in use.
 */
`timescale 1ns/1ps
`default_nettype none
module rcb_combine #(
    parameter int W = 32
) (
    // function
    input  wire logic [7:0]   code,
    // operands
    input  wire logic [W-1:0] src,
    input  wire logic [W-1:0] pat,
    input  wire logic [W-1:0] dst,
    output logic      [W-1:0] res
);
    initial begin
        if (W < 1) begin
            $error("rcb_combine: bad width");
        end
    end

    // ==================================================================
    // truth-table lookup, index {pattern, source, destination}
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            assign res[gi] = code[{pat[gi], src[gi], dst[gi]}];
        end
    endgenerate
endmodule
`default_nettype wire

// *** logic/rcb_top.sv ***
/*
 * rcb_top: raster function combiner of the 2D blit engine, with its
 * apb register block and a pixel operand port from the blit engine.
 * Assumes the blit engine runs on pclk and drives operands with a
 * one-cycle valid; no back-pressure is offered on that port.
 */
// The implementer's own choices: register access over APB and the placing of the registers.

`timescale 1ns/1ps
`default_nettype none
module rcb_top
    import rcb_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int PIXW   = 8
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // operands from the blit engine
    input  wire logic              op_valid,
    input  wire rcb_ops_t          op_data,
    // result to the blit engine
    output logic                   res_valid,
    output logic      [DATA_W-1:0] res_data,
    output logic                   busy
);

    // ==================================================================
    // elaboration checks
    initial begin
        if (DATA_W != WORD_W) begin
            $error("rcb_top: DATA_W must equal the package word width");
        end
        if (PIXW < 1 || (DATA_W % PIXW) != 0) begin
            $error("rcb_top: pixel width must divide the word");
        end
    end

    localparam int NPIX = DATA_W / PIXW;

    // ==================================================================
    // address decode, shared by the read and write paths
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        logic [2:0] idx;
        idx = 3'h7;
        unique case (a)
            OFS_RFCODE: idx = 3'h0;
            OFS_BLTCMD: idx = 3'h1;
            OFS_EXEC:   idx = 3'h2;
            OFS_STATUS: idx = 3'h3;
            OFS_COUNT:  idx = 3'h4;
            OFS_LAST:   idx = 3'h5;
            OFS_ACTIVE: idx = 3'h6;
            default:    idx = 3'h7;
        endcase
        return idx;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return reg_index(a) != 3'h7;
    endfunction

    // ==================================================================
    // apb handshake: one access cycle, no wait states
    logic        setup_c;
    logic        wr_acc;
    logic [2:0]  wr_idx;
    logic [31:0] wmask;

    assign setup_c = psel & ~penable;
    assign wr_acc  = psel & penable & pready & pwrite & ~pslverr;
    assign wr_idx  = reg_index(paddr);
    assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_c;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_c & ~mapped(paddr);
        end
    end

    // ==================================================================
    // software-staged setup
    logic [CODE_W-1:0] code_r;
    logic [8:0]        cmd_r;
    logic [31:0]       code_nxt;
    logic [31:0]       cmd_nxt;

    assign code_nxt = ({24'h000000, code_r} & ~wmask) | (pwdata & wmask);
    assign cmd_nxt  = ({23'h000000, cmd_r} & ~wmask) | (pwdata & wmask);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            code_r <= RST_CODE;
        end else if (wr_acc && wr_idx == 3'h0) begin
            code_r <= code_nxt[CODE_LSB +: CODE_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_r <= RST_CMD;
        end else if (wr_acc && wr_idx == 3'h1) begin
            cmd_r <= cmd_nxt[8:0];
        end
    end

    // ==================================================================
    // execute: the code in place at this moment is the one used
    logic go_c;
    logic stop_c;

    assign go_c   = wr_acc && wr_idx == 3'h2 && pstrb[0] && pwdata[EXEC_GO];
    assign stop_c = wr_acc && wr_idx == 3'h2 && pstrb[0] && pwdata[EXEC_STOP];

    rcb_setup_t act_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_r <= '0;
        end else if (go_c) begin
            act_r.code     <= code_r;
            act_r.src_cpu  <= cmd_r[CMD_SRC_CPU];
            act_r.src_mono <= cmd_r[CMD_SRC_MONO];
            act_r.pat_mono <= cmd_r[CMD_PAT_MONO];
        end
    end

    rcb_state_t state_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= RCB_IDLE;
        end else begin
            unique case (state_r)
                RCB_IDLE: begin
                    if (go_c && !stop_c) begin
                        state_r <= RCB_RUN;
                    end
                end
                RCB_RUN: begin
                    if (stop_c) begin
                        state_r <= RCB_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
        end else begin
            busy <= (state_r == RCB_RUN && !stop_c) || (state_r == RCB_IDLE && go_c && !stop_c);
        end
    end

    // ==================================================================
    // stage 1: source choice and monochrome expansion
    logic              take_c;
    logic              src_mono_c;
    logic [DATA_W-1:0] src_sel;
    logic [DATA_W-1:0] src_exp;
    logic [DATA_W-1:0] pat_exp;

    assign take_c     = op_valid && state_r == RCB_RUN;
    assign src_sel    = act_r.src_cpu ? op_data.src_cpu : op_data.src_scr;
    // a screen source ignores the monochrome bit
    assign src_mono_c = act_r.src_cpu & act_r.src_mono;

    rcb_expand #(
        .PIX_BITS (PIXW),
        .PIX_N    (NPIX)
    ) u_src_exp (
        .mono (src_mono_c),
        .din  (src_sel),
        .dout (src_exp)
    );

    rcb_expand #(
        .PIX_BITS (PIXW),
        .PIX_N    (NPIX)
    ) u_pat_exp (
        .mono (act_r.pat_mono),
        .din  (op_data.pat),
        .dout (pat_exp)
    );

    logic              s1_vld_r;
    logic [DATA_W-1:0] s1_src_r;
    logic [DATA_W-1:0] s1_pat_r;
    logic [DATA_W-1:0] s1_dst_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_vld_r <= 1'b0;
        end else begin
            s1_vld_r <= take_c;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_src_r <= RST_WORD;
            s1_pat_r <= RST_WORD;
            s1_dst_r <= RST_WORD;
        end else if (take_c) begin
            s1_src_r <= src_exp;
            s1_pat_r <= pat_exp;
            s1_dst_r <= op_data.dst;  // destination is never expanded
        end
    end

    // ==================================================================
    // stage 2: the raster function itself
    logic [DATA_W-1:0] comb_res;

    // the code is taken from the active copy, so a write to the staged
    // code during a blit cannot change words already in flight
    rcb_combine #(
        .W (DATA_W)
    ) u_comb (
        .code (act_r.code),
        .src  (s1_src_r),
        .pat  (s1_pat_r),
        .dst  (s1_dst_r),
        .res  (comb_res)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_valid <= 1'b0;
        end else begin
            res_valid <= s1_vld_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_data <= RST_WORD;
        end else if (s1_vld_r) begin
            res_data <= comb_res;
        end
    end

    // ==================================================================
    // progress and error status
    logic [CNT_W-1:0] count_r;
    logic             drop_r;
    logic             done_r;
    logic             clr_c;

    assign clr_c = wr_acc && wr_idx == 3'h3 && pstrb[0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= RST_COUNT;
        end else if (go_c) begin
            count_r <= RST_COUNT;
        end else if (s1_vld_r) begin
            count_r <= count_r + 1'b1;
        end
    end

    // operand words outside a blit are dropped; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drop_r <= 1'b0;
        end else if (op_valid && state_r != RCB_RUN) begin
            drop_r <= 1'b1;
        end else if (clr_c && pwdata[STAT_DROP]) begin
            drop_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (stop_c && state_r == RCB_RUN) begin
            done_r <= 1'b1;
        end else if (clr_c && pwdata[STAT_DONE]) begin
            done_r <= 1'b0;
        end
    end

    // ==================================================================
    // read data, captured in the setup cycle
    logic [31:0] rd_c;

    always_comb begin
        rd_c = 32'h00000000;
        unique case (reg_index(paddr))
            3'h0: rd_c[CODE_LSB +: CODE_W] = code_r;
            3'h1: rd_c[8:0] = cmd_r;
            3'h2: rd_c = 32'h00000000;
            3'h3: begin
                rd_c[STAT_ACTIVE] = state_r == RCB_RUN;
                rd_c[STAT_DROP]   = drop_r;
                rd_c[STAT_DONE]   = done_r;
            end
            3'h4: rd_c[CNT_W-1:0] = count_r;
            3'h5: rd_c = res_data;
            3'h6: begin
                rd_c[CODE_W-1:0]   = act_r.code;
                rd_c[ACT_SRC_MONO] = act_r.src_mono;
                rd_c[ACT_SRC_CPU]  = act_r.src_cpu;
                rd_c[ACT_PAT_MONO] = act_r.pat_mono;
            end
            3'h7: rd_c = 32'h00000000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_c && !pwrite) begin
            prdata <= rd_c;
        end
    end

endmodule
`default_nettype wire

// *** sim/rcb_top_assertions.sv ***
/* rcb_top_assertions: port checks of the raster function combiner.
   Assumes a bind onto rcb_top, one clock, async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module rcb_top_assertions
    import rcb_pkg::*;
#(
    parameter int DATA_W = 32,
    parameter int PIXW   = 8
) (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // operands and result
    input wire logic              op_valid,
    input wire rcb_ops_t          op_data,
    input wire logic              res_valid,
    input wire logic [DATA_W-1:0] res_data,
    input wire logic              busy
);
    // ==========
    // common
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc_w = psel && penable && pready;
    wire exec_w = acc_w && pwrite && paddr == OFS_EXEC;

    // ==========
    // apb
    ready_first_a: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    unmapped_err_a: assert property (acc_w && paddr > OFS_ACTIVE |-> pslverr)
        else $error("unmapped access without error");
    go_busy_a: assert property (exec_w && pwdata[1:0] == 2'b01 |=> busy)
        else $error("go did not start a blit");
    stop_idle_a: assert property (exec_w && pwdata[1] |=> !busy)
        else $error("stop left the blit running");

    // ==========
    // operand path
    res_lat_a: assert property (op_valid && busy |-> ##2 res_valid)
        else $error("result not two cycles after operands");
    res_cause_a: assert property (res_valid |-> $past(op_valid, 2) && $past(busy, 2))
        else $error("result without taken operands");
    res_hold_a: assert property (!res_valid |-> $stable(res_data))
        else $error("result changed without valid");

    cover property (op_valid && busy ##1 op_valid && busy);
    cover property (acc_w && pslverr);
    cover property (op_valid && !busy);
endmodule
`default_nettype wire

bind rcb_top rcb_top_assertions #(.DATA_W(DATA_W), .PIXW(PIXW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_data(op_data), .res_valid(res_valid),
    .res_data(res_data), .busy(busy));

// *** sim/rcb_blit_model.sv ***
/* rcb_blit_model: blit engine side, hands one operand word per request.
   Assumes the bench raises send for one cycle per word, on pclk. */
`timescale 1ns/1ps
`default_nettype none
module rcb_blit_model
    import rcb_pkg::*;
(
    // clock and reset
    input  wire logic     pclk,
    input  wire logic     presetn,
    // request from the bench
    input  wire logic     send,
    input  wire rcb_ops_t word,
    // operand port
    output var logic      op_valid,
    output var rcb_ops_t  op_data
);
    // ==========
    // operand driver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_valid <= 1'b0;
            op_data  <= '0;
        end else if (send) begin
            op_valid <= 1'b1;
            op_data  <= word;
        end else begin
            op_valid <= 1'b0;
            // no pull on these lines: a stale word must not pass for data
            op_data  <= ~op_data;
        end
    end
endmodule
`default_nettype wire

// *** sim/raster_op_combiner_tb.sv ***
/* raster_op_combiner_tb: self-checking bench of rcb_top.
   Assumes rcb_blit_model as operand source and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module raster_op_combiner_tb
    import rcb_pkg::*;
;
    // ==========
    // signals
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        send = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, res_data, rd, err;
    logic        pready, pslverr, op_valid, res_valid, busy;
    rcb_ops_t    op_data;
    rcb_ops_t    word = '0;
    logic [31:0] got[$];
    int          n_fail = 0;
    int          tests_run = 0;

    always #12.5 pclk = ~pclk;

    rcb_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_data(op_data), .res_valid(res_valid),
        .res_data(res_data), .busy(busy));
    rcb_blit_model u_blit (.pclk(pclk), .presetn(presetn), .send(send), .word(word),
        .op_valid(op_valid), .op_data(op_data));

    always @(posedge pclk) if (res_valid === 1'b1) got.push_back(res_data);

    // ==========
    // helpers
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_up(input string what);
        n_fail++;
        $display("MISMATCH %s expected answer seen timeout", what);
        close_out();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) give_up("apb ready");
        rd = prdata;
        err = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so psel is never assigned twice in a step
        @(posedge pclk);
    endtask

    task automatic push(input rcb_ops_t w);
        send <= 1'b1;
        word <= w;
        @(posedge pclk);
    endtask

    task automatic collect(input int n);
        send <= 1'b0;
        for (int k = 0; k < 12 && got.size() < n; k++) @(posedge pclk);
        if (got.size() < n) give_up("result count");
    endtask

    task automatic blit1(input logic [7:0] c, input logic [8:0] cmd, input rcb_ops_t w,
                         output logic [31:0] r);
        apb(1'b1, OFS_RFCODE, {24'h0, c});
        apb(1'b1, OFS_BLTCMD, {23'h0, cmd});
        apb(1'b1, OFS_EXEC, 32'h1);
        got.delete();
        push(w);
        collect(1);
        r = got[0];
        apb(1'b1, OFS_EXEC, 32'h2);
    endtask

    function automatic logic [31:0] tt(input logic [7:0] c, input logic [31:0] s, p, d);
        for (int i = 0; i < 32; i++) tt[i] = c[{p[i], s[i], d[i]}];
    endfunction

    function automatic logic [31:0] named(input logic [7:0] c, input logic [31:0] s, p, d);
        case (c)
            8'h00: named = 32'h0;
            8'h0F: named = ~p;
            8'h33: named = ~s;
            8'h55: named = ~d;
            8'h5A: named = p ^ d;
            8'h66: named = d ^ s;
            8'h88: named = d & s;
            8'h16: named = ((~(p & s)) & d) ^ s ^ p;
            8'h01: named = ~(d | (p | s));
            8'h1E: named = p ^ (d | s);
            8'h80: named = d & (p & s);
            default: named = tt(c, s, p, d);
        endcase
    endfunction

    function automatic logic [31:0] grow(input logic [31:0] m);
        for (int i = 0; i < 4; i++) grow[8*i +: 8] = {8{m[i]}};
    endfunction

    // ==========
    // scenarios
    task automatic t_regs;
        apb(1'b0, OFS_BLTCMD, 32'h0);
        chk("command reset", 32'h0, rd);
        apb(1'b1, OFS_BLTCMD, 32'hFFFF_FFFF);
        apb(1'b0, OFS_BLTCMD, 32'h0);
        chk("command bits", 32'h0000_01FF, rd);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped error", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
    endtask

    task automatic t_codes;
        logic [31:0] r;
        rcb_ops_t    w;
        // the low 16 bits hold every pattern, source, destination mix
        w = {32'h0F0F_0F0F, 32'hF0F0_F0F0, 32'hFF00_FF00, 32'hCCCC_CCCC};
        for (int c = 0; c < 256; c++) begin
            blit1(c[7:0], 9'h000, w, r);
            chk("code result", named(c[7:0], w.src_scr, w.pat, w.dst), r);
        end
    endtask

    task automatic t_modes;
        logic [31:0] r, s, p;
        rcb_ops_t    w;
        w = {32'h3C5A_9605, 32'h1234_5678, 32'hA5C3_0F0A, 32'h6E6E_9191};
        for (int i = 0; i < 8; i++) begin
            s = !i[1] ? w.src_scr : (i[0] ? grow(w.src_cpu) : w.src_cpu);
            p = i[2] ? grow(w.pat) : w.pat;
            blit1(8'hCC, {i[2:0], 6'h00}, w, r);
            chk("source operand", s, r);
            blit1(8'hF0, {i[2:0], 6'h00}, w, r);
            chk("pattern operand", p, r);
            blit1(8'hAA, {i[2:0], 6'h00}, w, r);
            chk("destination operand", w.dst, r);
        end
    endtask

    task automatic t_stream;
        rcb_ops_t q[4];
        apb(1'b1, OFS_RFCODE, 32'h96);
        apb(1'b1, OFS_BLTCMD, 32'h0);
        apb(1'b1, OFS_EXEC, 32'h1);
        got.delete();
        for (int i = 0; i < 4; i++) begin
            q[i] = {32'h0, 32'h0F0F_0F0F ^ i, 32'h3355_AA11 + i, 32'h9999_6666 << i};
            push(q[i]);
        end
        collect(4);
        for (int i = 0; i < 4; i++) chk("stream result", q[i].src_scr ^ q[i].pat ^ q[i].dst, got[i]);
        apb(1'b0, OFS_COUNT, 32'h0);
        chk("result count", 32'h4, rd);
        apb(1'b0, OFS_LAST, 32'h0);
        chk("last result", q[3].src_scr ^ q[3].pat ^ q[3].dst, rd);
        apb(1'b0, OFS_ACTIVE, 32'h0);
        chk("active setup", 32'h0000_0096, rd);
        apb(1'b1, OFS_EXEC, 32'h2);
        got.delete();
        push(q[0]);
        send <= 1'b0;
        repeat (6) @(posedge pclk);
        chk("idle results", 32'h0, 32'(got.size()));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("drop and done", 32'h6, rd);
        apb(1'b1, OFS_STATUS, 32'h6);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status cleared", 32'h0, rd);
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_codes();
        t_modes();
        t_stream();
        close_out();
    end
endmodule
`default_nettype wire
